/* File: hw/slpc_pkg.sv */
// Constants, types and register layout of the SDRAM low-power sequencer.
// Assumes the sequencer shares its clock with the memory controller it drives.
//
// Functional notes
// - Device sleeps on low-power interface request.
// - Program device, init memory, then issue Go.
// - After Go, poll status until Ready.
// - Pause from Ready, wait for Paused.
// - Configure from Paused, wait for Config.
// - Sleep only after Paused is reported.
// - Wakeup, wait Paused, then Go, wait Ready.
// - Low-power interface request brings device out.
// - Restart every stopped clock before wake-up.
// - Remove bus power only with split domains.
// - Restore bus power, pulse bus reset, stay asleep.
// - Prefer both clocks stopped in self-refresh.
package slpc_pkg;

  // Clock period of the sequencer in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 25;

  // Time the device clocks need after restart before a command.
  localparam int unsigned CLK_SETTLE_NS = 200;
  // Time the bus power domain needs to come up.
  localparam int unsigned PWR_SETTLE_NS = 10000;
  // Least time the bus-domain reset of the device is held.
  localparam int unsigned RST_HOLD_NS   = 1000;
  // Cycle counts derived from the times; least times round up.
  localparam int unsigned CLK_SETTLE_CYC = (CLK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PWR_SETTLE_CYC = (PWR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_HOLD_CYC   = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Default number of status polls before a sequence gives up.
  localparam int unsigned POLL_LIMIT_DEF = 1024;

  // Offsets of the sequencer's own registers.
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_DADDR  = 8'h04;
  localparam logic [7:0] REG_DWDATA = 8'h08;
  localparam logic [7:0] REG_DRDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_CFG    = 8'h14;

  // Field positions of the status register.
  localparam int unsigned ST_BUSY    = 0;
  localparam int unsigned ST_STATE   = 1;
  localparam int unsigned ST_ERR     = 3;
  localparam int unsigned ST_ACK     = 4;
  localparam int unsigned ST_ACTIVE  = 5;
  localparam int unsigned ST_PWROFF  = 6;
  localparam int unsigned ST_CLKSTOP = 7;
  // Field positions and reset value of the configuration register.
  localparam int unsigned CFG_STOPCLK = 0;
  localparam int unsigned CFG_PWROFF  = 1;
  localparam logic [1:0]  CFG_RESET   = 2'h1;

  // Device state codes read back from its status field.
  localparam logic [1:0] DEV_CONFIG = 2'h0;
  localparam logic [1:0] DEV_READY  = 2'h1;
  localparam logic [1:0] DEV_PAUSED = 2'h2;
  localparam logic [1:0] DEV_LOWPWR = 2'h3;

  // Operations that software starts by writing the command register.
  typedef enum logic [3:0] {
    OP_GO       = 4'h0,
    OP_PAUSE    = 4'h1,
    OP_CONFIG   = 4'h2,
    OP_SLEEP    = 4'h3,
    OP_WAKE     = 4'h4,
    OP_HW_SLEEP = 4'h5,
    OP_HW_WAKE  = 4'h6,
    OP_RAW_WR   = 4'h7,
    OP_RAW_RD   = 4'h8
  } slpc_op_t;

  // One register access towards the device.
  typedef struct packed {
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } slpc_req_t;

  // Register-port pins driven towards the device.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } slpc_apb_t;

  // One device command paired with the status that confirms it.
  typedef struct packed {
    logic       valid;
    logic [2:0] cmd;
    logic [1:0] want;
  } slpc_pair_t;

endpackage

/* File: hw/slpc_apb_master.sv */
// Single-access register-port master towards the memory controller.
// Assumes the device register port runs on the same clock, with wait states.
module slpc_apb_master
  import slpc_pkg::*;
(
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Request side.
  input  wire logic                start,
  input  wire slpc_pkg::slpc_req_t req,
  output logic                     done,
  output logic [31:0]              rdata_q,
  // Device side.
  output slpc_pkg::slpc_apb_t      apb_q,
  input  wire logic [31:0]         prdata,
  input  wire logic                pready
);

  // Transfer phase of the port.
  typedef enum logic [1:0] {M_IDLE, M_SETUP, M_ACCESS} slpc_mph_t;
  slpc_mph_t ph_q;

  // The phase advances; a start outside idle is dropped by the caller's design.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ph_q <= M_IDLE;
    else
    begin
      unique case (ph_q)
        M_IDLE:   if (start) ph_q <= M_SETUP;
        M_SETUP:  ph_q <= M_ACCESS;
        M_ACCESS: if (pready) ph_q <= M_IDLE;
      endcase
    end
  end

  // Pins are held steady from setup until the device answers.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      apb_q <= '0;
    else if (ph_q == M_IDLE && start)
    begin
      apb_q.psel    <= 1'b1;
      apb_q.penable <= 1'b0;
      apb_q.pwrite  <= req.write;
      apb_q.paddr   <= req.addr;
      apb_q.pwdata  <= req.wdata;
    end
    else if (ph_q == M_SETUP)
      apb_q.penable <= 1'b1;
    else if (ph_q == M_ACCESS && pready)
    begin
      apb_q.psel    <= 1'b0;
      apb_q.penable <= 1'b0;
    end
  end

  // Read data are caught on the completing cycle and held.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_q <= '0;
    else if (ph_q == M_ACCESS && pready && !apb_q.pwrite)
      rdata_q <= prdata;
  end

  // Completion is a one-cycle pulse in the cycle the device answers.
  assign done = (ph_q == M_ACCESS) && pready;

endmodule

/* File: hw/slpc_ctrl.sv */
// Low-power sequencer that drives a memory controller through its register
// port and its low-power handshake, and steers clock stop and bus power.
// Assumes all device pins are synchronous to clk and clocks are gated outside.
//
// Added by the designer: the plain strobed port and the placing of the registers.
module slpc_ctrl
  import slpc_pkg::*;
#(
  parameter logic [11:0] DEV_STATUS_ADDR = 12'h000,  // Device status register.
  parameter logic [11:0] DEV_CMD_ADDR    = 12'h004,  // Device command register.
  parameter logic [2:0]  DCMD_GO         = 3'h0,     // Go command code.
  parameter logic [2:0]  DCMD_SLEEP      = 3'h1,     // Sleep command code.
  parameter logic [2:0]  DCMD_WAKEUP     = 3'h2,     // Wakeup command code.
  parameter logic [2:0]  DCMD_PAUSE      = 3'h3,     // Pause command code.
  parameter logic [2:0]  DCMD_CONFIGURE  = 3'h4,     // Configure command code.
  parameter bit          SPLIT_DOMAINS   = 1'b1,     // Device has split power domains.
  parameter int unsigned POLL_LIMIT      = slpc_pkg::POLL_LIMIT_DEF,
  parameter int unsigned PWR_SETTLE      = slpc_pkg::PWR_SETTLE_CYC,
  parameter int unsigned RST_HOLD        = slpc_pkg::RST_HOLD_CYC,
  parameter int unsigned CLK_SETTLE      = slpc_pkg::CLK_SETTLE_CYC
)
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Software register port.
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata_q,
  // Device register port.
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  // Device low-power handshake.
  output logic             csysreq,
  input  wire logic        csysack,
  input  wire logic        cactive,
  // Clock, power and reset control of the device domains.
  output logic             bus_clk_stop_q,
  output logic             mem_clk_stop_q,
  output logic             bus_pwr_en_q,
  output logic             bus_rst_n_q
);

  import slpc_pkg::*;

  // Sequencer states.
  typedef enum logic [3:0] {
    S_IDLE, S_PWR_ON, S_RST_HOLD, S_SETTLE, S_PROBE, S_PROBE_WAIT,
    S_NEXT, S_CMD, S_CMD_WAIT, S_POLL, S_POLL_WAIT, S_LP_REQ, S_PARK,
    S_RAW, S_RAW_WAIT
  } slpc_state_t;

  slpc_state_t state_q;           // Current sequencer state.
  slpc_op_t    op_q;              // Operation in progress.
  logic [1:0]  cfg_q;             // Clock-stop and power-off choices.
  logic [11:0] daddr_q;           // Device address for raw access.
  logic [31:0] dwdata_q;          // Device write data for raw access.
  logic [31:0] drdata_q;          // Last raw read result.
  logic [1:0]  dev_state_q;       // Last device status seen.
  logic        err_q;             // Sticky timeout flag.
  logic        csysreq_q;         // Low-power request, high means run.
  logic        step_q;            // Index of the command pair in a sequence.
  logic [15:0] tmr_q;             // Settle and hold timer.
  logic [15:0] poll_q;            // Poll attempts in the current wait.
  slpc_pair_t  pair;              // Pair chosen for the current step.
  slpc_req_t   mreq;              // Access handed to the port master.
  logic        mstart;            // Starts one device access.
  logic        mdone;             // Device access has completed.
  logic [31:0] mrdata;            // Device read data, valid in the completing cycle.
  slpc_apb_t   apb;               // Device port pins from the master.
  logic        cmd_wr;            // Software write of an operation.
  logic        busy;              // A sequence is running.

  // Picks the device command and expected status for a step of an operation.
  function automatic slpc_pair_t pick_pair(slpc_op_t op, logic step, logic [1:0] st);
    slpc_pair_t p;
    p = '0;
    unique case (op)
      OP_GO:     if (!step) p = '{1'b1, DCMD_GO, DEV_READY};
      OP_PAUSE:  if (!step) p = '{1'b1, DCMD_PAUSE, DEV_PAUSED};
      OP_CONFIG:
      begin
        if (!step && st != DEV_PAUSED)
          p = '{1'b1, DCMD_PAUSE, DEV_PAUSED};
        else if (!step || st == DEV_PAUSED)
          p = '{1'b1, DCMD_CONFIGURE, DEV_CONFIG};
      end
      // Sleep is sent only once Paused is seen.
      OP_SLEEP:
      begin
        if (!step && st != DEV_PAUSED)
          p = '{1'b1, DCMD_PAUSE, DEV_PAUSED};
        else if (st == DEV_PAUSED)
          p = '{1'b1, DCMD_SLEEP, DEV_LOWPWR};
      end
      // Wakeup to Paused, then Go to Ready.
      OP_WAKE:
      begin
        if (!step)
          p = '{1'b1, DCMD_WAKEUP, DEV_PAUSED};
        else
          p = '{1'b1, DCMD_GO, DEV_READY};
      end
      default: p = '0;
    endcase
    return p;
  endfunction

  assign busy   = (state_q != S_IDLE);
  assign cmd_wr = wr && (addr == REG_CMD) && !busy;
  assign pair   = pick_pair(op_q, step_q, dev_state_q);

  // Software configuration and raw access registers.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cfg_q    <= CFG_RESET;
      daddr_q  <= '0;
      dwdata_q <= '0;
    end
    else if (wr)
    begin
      // The raw access registers hold still while busy; the configuration register takes writes at any time.
      if (addr == REG_CFG)
        cfg_q <= wdata[1:0];
      else if (addr == REG_DADDR && !busy)
        daddr_q <= wdata[11:0];
      else if (addr == REG_DWDATA && !busy)
        dwdata_q <= wdata;
    end
  end

  // Operation latch; a write during a sequence is refused.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      op_q <= OP_GO;
    else if (cmd_wr)
      op_q <= slpc_op_t'(wdata[3:0]);
  end

  // Main sequencer.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_q <= S_IDLE;
    else
    begin
      unique case (state_q)
        S_IDLE:
        begin
          if (cmd_wr)
          begin
            unique case (wdata[3:0])
              OP_WAKE, OP_HW_WAKE:
                // Restore bus power before any wake.
                state_q <= bus_pwr_en_q ? S_SETTLE : S_PWR_ON;
              OP_HW_SLEEP:           state_q <= S_LP_REQ;
              OP_RAW_WR, OP_RAW_RD:  state_q <= S_RAW;
              OP_GO, OP_PAUSE, OP_CONFIG, OP_SLEEP: state_q <= S_PROBE;
              // Unknown operation codes are ignored.
              default:               state_q <= S_IDLE;
            endcase
          end
        end
        S_PWR_ON:   if (tmr_q == 16'h0000) state_q <= S_RST_HOLD;
        S_RST_HOLD: if (tmr_q == 16'h0000) state_q <= S_SETTLE;
        S_SETTLE:
        begin
          if (tmr_q == 16'h0000)
            state_q <= (op_q == OP_HW_WAKE) ? S_LP_REQ : S_PROBE;
        end
        S_PROBE:      state_q <= S_PROBE_WAIT;
        S_PROBE_WAIT: if (mdone) state_q <= S_NEXT;
        S_NEXT:
        begin
          if (pair.valid)
            state_q <= S_CMD;
          else if (op_q == OP_SLEEP)
            state_q <= S_PARK;
          else
            state_q <= S_IDLE;
        end
        S_CMD:      state_q <= S_CMD_WAIT;
        S_CMD_WAIT: if (mdone) state_q <= S_POLL;
        S_POLL:     state_q <= S_POLL_WAIT;
        S_POLL_WAIT:
        begin
          if (mdone)
          begin
            if (mrdata[1:0] == pair.want)
              state_q <= (step_q || op_q == OP_GO || op_q == OP_PAUSE) ?
                         ((op_q == OP_SLEEP) ? S_PARK : S_IDLE) : S_NEXT;
            else if (poll_q >= 16'(POLL_LIMIT - 1))
              state_q <= S_IDLE;
            else
              state_q <= S_POLL;
          end
        end
        S_LP_REQ:
        begin
          // Wait for the device to follow the request level.
          if (csysack == csysreq_q)
            state_q <= (op_q == OP_HW_SLEEP) ? S_PARK : S_IDLE;
          else if (poll_q >= 16'(POLL_LIMIT - 1))
            state_q <= S_IDLE;
        end
        S_PARK:     state_q <= S_IDLE;
        S_RAW:      state_q <= S_RAW_WAIT;
        S_RAW_WAIT: if (mdone) state_q <= S_IDLE;
      endcase
    end
  end

  // Step index within a two-pair sequence.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      step_q <= 1'b0;
    else if (state_q == S_PROBE)
      step_q <= 1'b0;
    else if (state_q == S_POLL_WAIT && mdone && mrdata[1:0] == pair.want)
      step_q <= 1'b1;
  end

  // Settle timer, loaded on entry to each timed state.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      tmr_q <= '0;
    else if (state_q == S_IDLE && cmd_wr)
      tmr_q <= bus_pwr_en_q ? 16'(CLK_SETTLE - 1) : 16'(PWR_SETTLE - 1);
    else if (state_q == S_PWR_ON && tmr_q == 16'h0000)
      tmr_q <= 16'(RST_HOLD - 1);
    else if (state_q == S_RST_HOLD && tmr_q == 16'h0000)
      tmr_q <= 16'(CLK_SETTLE - 1);
    else if (tmr_q != 16'h0000)
      tmr_q <= tmr_q - 16'h0001;
  end

  // Poll counter, restarted by each command write and each handshake.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      poll_q <= '0;
    else if (state_q == S_CMD || state_q == S_IDLE)
      poll_q <= '0;
    else if ((state_q == S_POLL_WAIT && mdone) || state_q == S_LP_REQ)
      poll_q <= poll_q + 16'h0001;
  end

  // Sticky timeout flag; a new operation clears it.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      err_q <= 1'b0;
    else if ((state_q == S_POLL_WAIT && mdone && mrdata[1:0] != pair.want
              && poll_q >= 16'(POLL_LIMIT - 1))
             || (state_q == S_LP_REQ && csysack != csysreq_q
              && poll_q >= 16'(POLL_LIMIT - 1)))
      err_q <= 1'b1;
    else if (cmd_wr)
      err_q <= 1'b0;
  end

  // Device state as last read, and raw read data.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      // A freshly reset device sits in Config.
      dev_state_q <= DEV_CONFIG;
      drdata_q    <= '0;
    end
    else if (mdone && (state_q == S_PROBE_WAIT || state_q == S_POLL_WAIT))
      // After a bus power restore the probe shows sleep.
      dev_state_q <= mrdata[1:0];
    else if (mdone && state_q == S_RAW_WAIT && op_q == OP_RAW_RD)
      drdata_q <= mrdata;
  end

  // Low-power request level; high while the device should run.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      csysreq_q <= 1'b1;
    else if (state_q == S_IDLE && cmd_wr && wdata[3:0] == OP_HW_SLEEP)
      csysreq_q <= 1'b0;
    else if (state_q == S_SETTLE && tmr_q == 16'h0000 && op_q == OP_HW_WAKE)
      csysreq_q <= 1'b1;
  end

  // Clock stop and bus power, applied only once self-refresh is reached.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bus_clk_stop_q <= 1'b0;
      mem_clk_stop_q <= 1'b0;
      bus_pwr_en_q   <= 1'b1;
    end
    else if (state_q == S_PARK)
    begin
      bus_clk_stop_q <= cfg_q[CFG_STOPCLK];
      mem_clk_stop_q <= cfg_q[CFG_STOPCLK];
      // Bus power goes only with split domains.
      if (SPLIT_DOMAINS && cfg_q[CFG_PWROFF])
        bus_pwr_en_q <= 1'b0;
    end
    else if (state_q == S_PWR_ON)
      bus_pwr_en_q <= 1'b1;
    else if (state_q == S_RST_HOLD)
    begin
      // Clocks restart before the wake commands.
      bus_clk_stop_q <= 1'b0;
      mem_clk_stop_q <= 1'b0;
    end
    else if (state_q == S_SETTLE)
    begin
      bus_clk_stop_q <= 1'b0;
      mem_clk_stop_q <= 1'b0;
    end
  end

  // Bus-domain reset of the device, pulsed after a power restore.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      bus_rst_n_q <= 1'b1;
    else
      // Reset held while the restore hold runs.
      bus_rst_n_q <= (state_q != S_RST_HOLD);
  end

  // Access request to the port master.
  always_comb
  begin
    mstart = 1'b0;
    mreq   = '{1'b0, DEV_STATUS_ADDR, 32'h0000_0000};
    unique case (state_q)
      S_PROBE, S_POLL:
        mstart = 1'b1;
      S_CMD:
      begin
        // Commands go through the device command register.
        mstart = 1'b1;
        mreq   = '{1'b1, DEV_CMD_ADDR, {29'h0000_0000, pair.cmd}};
      end
      S_RAW:
      begin
        // Software programs the device through raw accesses.
        mstart = 1'b1;
        mreq   = '{(op_q == OP_RAW_WR), daddr_q, dwdata_q};
      end
      default:
        mstart = 1'b0;
    endcase
  end

  // Register-port master towards the device.
  slpc_apb_master u_master (
    .clk     (clk),
    .rst_n   (rst_n),
    .start   (mstart),
    .req     (mreq),
    .done    (mdone),
    .rdata_q (),
    .apb_q   (apb),
    .prdata  (prdata),
    .pready  (pready)
  );

  assign psel    = apb.psel;
  assign penable = apb.penable;
  assign pwrite  = apb.pwrite;
  assign paddr   = apb.paddr;
  assign pwdata  = apb.pwdata;
  assign csysreq = csysreq_q;
  // The master's register lags the completing edge, so decisions take the live data.
  assign mrdata  = prdata;

  // Software read port, data in the cycle after the strobe.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_q <= '0;
    else if (rd)
    begin
      unique case (addr)
        REG_DADDR:  rdata_q <= {20'h00000, daddr_q};
        REG_DWDATA: rdata_q <= dwdata_q;
        REG_DRDATA: rdata_q <= drdata_q;
        REG_STATUS: rdata_q <= {24'h000000, mem_clk_stop_q, ~bus_pwr_en_q, cactive,
                                csysack, err_q, dev_state_q, busy};
        REG_CFG:    rdata_q <= {30'h00000000, cfg_q};
        // Unmapped offsets and the command register read as zero.
        default:    rdata_q <= '0;
      endcase
    end
    else
      rdata_q <= '0;
  end

endmodule

/* File: tb/slpc_dev_model.sv */
// Behavioural memory controller: state code, scratch word and handshake.
// Assumes the sequencer's clock; slow adds one wait state to each access.
module slpc_dev_model
  import slpc_pkg::*;
(
  // Clock and resets.
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        bus_rst_n,
  // Register port.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  input  wire logic        slow,
  // Low-power handshake.
  input  wire logic        csysreq,
  output logic             csysack,
  output logic             cactive
);
  logic [1:0]  st_q;   // State code.
  logic [31:0] scr_q;  // Scratch word.
  logic [31:0] cyc_q;  // Cycle count.
  logic        wt_q;   // A wait state has passed.
  logic        done;   // Access ends here.

  assign done    = psel && penable && pready;
  assign pready  = !slow || wt_q;
  assign cactive = (st_q != DEV_LOWPWR);
  // An idle port shows a moving pattern, so stale data never looks valid.
  assign prdata  = !(psel && penable) ? cyc_q : (paddr == 12'h000) ? {30'h0, st_q}
                 : (paddr == 12'h008) ? scr_q : 32'h0;

  // State moves on commands, handshake and bus-domain reset.
  always_ff @(posedge clk)
  begin
    cyc_q   <= cyc_q + 32'h1;
    wt_q    <= psel && penable && !done;
    csysack <= csysreq;
    if (!rst_n)
    begin
      st_q  <= DEV_CONFIG;
      scr_q <= 32'h0;
    end
    else if (!bus_rst_n)
      st_q <= (st_q == DEV_LOWPWR) ? DEV_LOWPWR : DEV_CONFIG;
    else if (!csysreq)
      st_q <= DEV_LOWPWR;
    else if (!csysack && st_q == DEV_LOWPWR)
      st_q <= DEV_READY;
    else if (done && pwrite && paddr == 12'h008)
      scr_q <= pwdata;
    else if (done && pwrite && paddr == 12'h004)
    begin
      case (pwdata[2:0])
        3'h0: st_q <= (st_q == DEV_LOWPWR) ? st_q : DEV_READY;
        3'h1: st_q <= (st_q == DEV_PAUSED) ? DEV_LOWPWR : st_q;
        3'h2: st_q <= (st_q == DEV_LOWPWR) ? DEV_PAUSED : st_q;
        3'h3: st_q <= (st_q == DEV_READY) ? DEV_PAUSED : st_q;
        3'h4: st_q <= (st_q == DEV_PAUSED) ? DEV_CONFIG : st_q;
        default: st_q <= st_q;
      endcase
    end
  end
endmodule

/* File: tb/slpc_ctrl_asserts.sv */
// Pin checker bound to every sequencer instance.
// Assumes one clock and a synchronous active-low reset.
module slpc_ctrl_asserts #(
  parameter int unsigned RST_HOLD = 2
)
(
  // Clock, reset and software port.
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  addr,
  input wire logic        rd,
  input wire logic [31:0] rdata_q,
  // Device side.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        csysreq,
  input wire logic        csysack,
  input wire logic        bus_clk_stop_q,
  input wire logic        mem_clk_stop_q,
  input wire logic        bus_pwr_en_q,
  input wire logic        bus_rst_n_q
);
  int unsigned lo_q;  // Low cycles of the bus-domain reset.

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Count how long the bus-domain reset has been held.
  always_ff @(posedge clk)
  begin
    if (!rst_n || bus_rst_n_q)
      lo_q <= 0;
    else
      lo_q <= lo_q + 1;
  end

  a_reset_rest: assert property ($rose(rst_n) |-> csysreq && bus_pwr_en_q && bus_rst_n_q
    && !mem_clk_stop_q && !psel) else $error("not at rest");
  a_apb_setup: assert property ($rose(psel) |-> !penable ##1 psel && penable)
    else $error("setup phase missing");
  a_apb_hold: assert property (psel && penable && !pready |=> psel && penable
    && $stable(paddr) && $stable(pwdata) && $stable(pwrite)) else $error("access changed");
  a_apb_gap: assert property (psel && penable && pready |=> !psel)
    else $error("access not released");
  a_rdata_idle: assert property (!$past(rd) |-> rdata_q == 32'h0)
    else $error("read data stale");
  a_unmapped_zero: assert property (rd && addr == 8'h20 |=> rdata_q == 32'h0)
    else $error("unmapped read not zero");
  a_idle_when_off: assert property ((mem_clk_stop_q || bus_clk_stop_q || !bus_pwr_en_q
    || !bus_rst_n_q) |-> !psel) else $error("access while off");
  a_wake_ready: assert property ($rose(csysreq) |-> !bus_clk_stop_q && !mem_clk_stop_q
    && bus_pwr_en_q && bus_rst_n_q) else $error("early wake");
  a_rst_hold: assert property ($rose(bus_rst_n_q) |-> lo_q >= RST_HOLD)
    else $error("bus reset too short");
  a_pwr_in_sleep: assert property ($fell(bus_pwr_en_q) |-> !csysreq && !csysack)
    else $error("early power off");
  a_req_held: assert property (!csysreq && csysack |=> !csysreq)
    else $error("request dropped");

  c_slow: cover property (psel && penable && !pready);
  c_pwr_off: cover property ($fell(bus_pwr_en_q));
  c_clk_stop: cover property ($rose(mem_clk_stop_q) && csysreq);
endmodule

bind slpc_ctrl slpc_ctrl_asserts #(.RST_HOLD(RST_HOLD)) i_slpc_ctrl_asserts (.clk, .rst_n,
  .addr, .rd, .rdata_q, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .csysreq,
  .csysack, .bus_clk_stop_q, .mem_clk_stop_q, .bus_pwr_en_q, .bus_rst_n_q);

/* File: tb/tb.sv */
// Bench of the sequencer against the device model, with a table of expected states.
// Assumes default device addresses and command codes of the sequencer.
module tb import slpc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, slow = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, seed = 32'h00015c63, s, rdata_q, prdata, pwdata;
  logic [11:0] paddr;
  logic        psel, penable, pwrite, pready, csysreq, csysack, cactive;
  logic        bus_clk_stop_q, mem_clk_stop_q, bus_pwr_en_q, bus_rst_n_q;
  logic [4:0]  pins;
  int          n_fail = 0, comparisons = 0;
  logic [31:0] exp_q[$];  // Random words awaiting read-back.
  slpc_op_t    ops[7] = '{OP_GO, OP_PAUSE, OP_CONFIG, OP_GO, OP_CONFIG, OP_GO, OP_SLEEP};
  logic [1:0]  sts[7] = '{DEV_READY, DEV_PAUSED, DEV_CONFIG, DEV_READY, DEV_CONFIG,
                          DEV_READY, DEV_LOWPWR};

  assign pins = {csysreq, bus_pwr_en_q, bus_rst_n_q, bus_clk_stop_q, mem_clk_stop_q};
  always #12.5 clk = ~clk;

  slpc_ctrl #(.POLL_LIMIT(8), .PWR_SETTLE(4), .RST_HOLD(2), .CLK_SETTLE(2)) i_slpc_ctrl (.*);
  slpc_dev_model i_slpc_dev_model (.*, .bus_rst_n(bus_rst_n_q));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_pins(input logic [4:0] exp);
    check({27'h0, pins}, {27'h0, exp});
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    slow  <= seed[0];
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata_q;
  endtask

  // Start an operation and poll until the sequencer is no longer busy.
  task automatic run_op(input slpc_op_t o);
    int n;
    n = 0;
    s = xs();
    wr_reg(REG_CMD, {28'h0, o});
    do
    begin
      rd_reg(REG_STATUS, s);
      n++;
    end
    while (s[ST_BUSY] !== 1'b0 && n < 500);
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence: state walk, raw accesses, handshake sleep, reset in mid-run.
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check_pins(5'h1c);
    rd_reg(REG_CFG, s);
    check(s, {30'h0, CFG_RESET});
    rd_reg(8'h20, s);
    check(s, 32'h0);
    foreach (ops[i])
    begin
      run_op(ops[i]);
      check({29'h0, s[ST_ERR], s[ST_STATE+:2]}, {30'h0, sts[i]});
    end
    check_pins(5'h1f);
    run_op(OP_WAKE);
    check({30'h0, s[ST_STATE+:2]}, {30'h0, DEV_READY});
    check_pins(5'h1c);
    for (int i = 0; i < 3; i++)
    begin
      exp_q.push_back(xs());
      wr_reg(REG_DADDR, 32'h8);
      wr_reg(REG_DWDATA, exp_q[$]);
      run_op(OP_RAW_WR);
      run_op(OP_RAW_RD);
      rd_reg(REG_DRDATA, s);
      check(s, exp_q.pop_front());
    end
    wr_reg(REG_CFG, 32'h3);
    run_op(OP_HW_SLEEP);
    check_pins(5'h07);
    check({28'h0, s[7:4]}, 32'hc);
    run_op(OP_HW_WAKE);
    check_pins(5'h1c);
    run_op(OP_PAUSE);
    check({30'h0, s[ST_STATE+:2]}, {30'h0, DEV_PAUSED});
    wr_reg(REG_CFG, 32'h0);
    run_op(OP_GO);
    run_op(OP_HW_SLEEP);
    check_pins(5'h0c);
    wr_reg(REG_CMD, {28'h0, OP_HW_WAKE});
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check_pins(5'h1c);
    run_op(OP_GO);
    check({30'h0, s[ST_STATE+:2]}, {30'h0, DEV_READY});
    complete_run();
  end

  // Cut a hang short well beyond the expected few hundred cycles.
  initial
  begin
    #1000000;
    n_fail++;
    complete_run();
  end
endmodule
